// ===== bench/asl_mem_model.sv
// word memory model answering the datapath's operand reads
`timescale 1ns/1ps
`default_nettype none
module asl_mem_model import asl_pkg::*; (
  input  wire logic                  clk,         // cpu clock
  input  wire logic                  reset_n,     // async reset, low
  input  wire logic [1:0]            latency,     // cycles from req to ack
  input  wire logic                  mem_rd_req,  // read request, level
  input  wire logic [WORD_WIDTH-1:0] mem_rd_addr, // read address
  output logic      [WORD_WIDTH-1:0] mem_rd_data, // data, valid with ack
  output logic                       mem_rd_ack   // answer pulse
);
  logic [WORD_WIDTH-1:0] mem [0:255];
  logic [1:0]            wait_reg;
  logic [WORD_WIDTH-1:0] last_reg;

  // count cycles of a standing request, restart after every answer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_reg <= 2'h0;
      last_reg <= 16'h0000;
    end else if (!mem_rd_req || mem_rd_ack) begin
      wait_reg <= 2'h0;
      if (mem_rd_ack) begin
        last_reg <= mem_rd_data;
      end
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end

  // latency 0 answers in the first request cycle
  assign mem_rd_ack = mem_rd_req && (wait_reg == latency);
  // off the answer the bus shows the inverse of its last value, so a
  // late sample sees wrong data instead of a lucky match
  assign mem_rd_data = mem_rd_ack ? mem[mem_rd_addr[7:0]] : ~last_reg;
endmodule // asl_mem_model
`default_nettype wire

// ===== bench/test_accumulator_stack_load.sv
// self-checking testbench of the accumulator and stack datapath
`timescale 1ns/1ps
`default_nettype none
module test_accumulator_stack_load;
  import asl_pkg::*;
  logic        clk, reset_n, clk_en, op_valid, op_use_const, op_use_ptr;
  asl_op_type  op_code;
  logic [15:0] op_addr, mem_rd_addr, mem_rd_data;
  logic [31:0] op_const, manip_result, acc_out, stack_top_out;
  logic        op_ready, op_done, zero_load_flag, mem_rd_req, mem_rd_ack;
  logic [1:0]  latency;
  logic [31:0] exp_acc;
  logic [31:0] exp_stk [0:7];
  logic        exp_pend, exp_flag;
  int          err_count, samples_checked;

  asl_top #(.LEVELS(STACK_DEPTH)) u_dut (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op_code), .op_use_const(op_use_const), .op_use_ptr(op_use_ptr),
    .op_addr(op_addr), .op_const(op_const), .manip_result(manip_result),
    .op_ready(op_ready), .op_done(op_done), .acc_out(acc_out),
    .stack_top_out(stack_top_out), .zero_load_flag(zero_load_flag),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .mem_rd_ack(mem_rd_ack));

  asl_mem_model u_mem (
    .clk(clk), .reset_n(reset_n), .latency(latency),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .mem_rd_ack(mem_rd_ack));

  // 25 MHz cpu clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic compare_state();
    check(acc_out, exp_acc);
    check(stack_top_out, exp_stk[0]);
    check({31'h0, zero_load_flag}, {31'h0, exp_flag});
  endtask

  // offer one instruction at a falling edge, hold it until taken
  task automatic run_op(input asl_op_type code, input logic uc, input logic up,
                        input logic [15:0] a, input logic [31:0] cv);
    int n;
    @(negedge clk);
    op_valid = 1'b1;
    op_code = code;
    op_use_const = uc;
    op_use_ptr = up;
    op_addr = a;
    op_const = cv;
    n = 0;
    while (op_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    op_valid = 1'b0;
    while (op_done !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, op_done, 1'b1);
    end
  endtask

  // a load pushes the old accumulator when one is pending
  task automatic load(input asl_op_type code, input logic uc, input logic up,
                      input logic [15:0] a, input logic [31:0] cv,
                      input logic [31:0] v);
    run_op(code, uc, up, a, cv);
    if (exp_pend) begin
      for (int i = 7; i > 0; i--) exp_stk[i] = exp_stk[i-1];
      exp_stk[0] = exp_acc;
    end
    exp_acc = v;
    exp_pend = 1'b1;
    exp_flag = (v == 32'h00000000);
    compare_state();
  endtask

  task automatic simple(input asl_op_type code);
    run_op(code, 1'b0, 1'b0, 16'h0000, 32'h00000000);
    case (code)
      OP_STORE: exp_pend = 1'b0;
      OP_MANIP: exp_acc = manip_result;
      OP_SCAN_END: begin
        exp_acc = 32'h00000000;
        exp_pend = 1'b0;
      end
      OP_POP: begin
        exp_acc = exp_stk[0];
        for (int i = 0; i < 7; i++) exp_stk[i] = exp_stk[i+1];
        exp_stk[7] = 32'h00000000;
      end
      default: ;
    endcase
    compare_state();
  endtask

  task automatic t_reset_state();
    compare_state();
    check({31'h0, op_ready}, 32'h00000001);
  endtask

  // ten word loads overflow the stack, nine pops drain it
  task automatic t_push_overflow();
    logic [15:0] w;
    simple(OP_SCAN_END);
    for (int i = 1; i <= 10; i++) begin
      w = 16'h1111 * i[15:0];
      load(OP_LOAD_WORD, 1'b1, 1'b0, 16'h0000, {16'hDEAD, w}, {16'h0, w});
    end
    for (int i = 0; i < 9; i++) simple(OP_POP);
  endtask

  task automatic t_store_scan();
    load(OP_LOAD_WORD, 1'b1, 1'b0, 16'h0000, 32'h00001234, 32'h00001234);
    simple(OP_STORE);
    load(OP_LOAD_WORD, 1'b1, 1'b0, 16'h0000, 32'h00000000, 32'h0);
    load(OP_LOAD_WORD, 1'b1, 1'b0, 16'h0000, 32'h00000005, 32'h5);
    simple(OP_SCAN_END);
    load(OP_LOAD_WORD, 1'b1, 1'b0, 16'h0000, 32'h00000007, 32'h7);
  endtask

  // memory operands at every answer latency, paired and indirect
  task automatic t_mem_loads();
    for (int l = 0; l < 4; l++) begin
      latency = l[1:0];
      u_mem.mem[16 + l] = 16'h8000 | l[15:0];
      load(OP_LOAD_WORD, 1'b0, 1'b0, 16'h0010 + l[15:0], 32'h0,
           {16'h0, 16'h8000 | l[15:0]});
    end
    u_mem.mem[8'h20] = 16'h4321;
    u_mem.mem[8'h21] = 16'h8765;
    load(OP_LOAD_DOUBLE, 1'b0, 1'b0, 16'h0020, 32'h0, 32'h87654321);
    load(OP_LOAD_DOUBLE, 1'b1, 1'b0, 16'h0000, 32'hF9999999, 32'hF9999999);
    u_mem.mem[8'h30] = 16'h0040;
    u_mem.mem[8'h40] = 16'hBEEF;
    load(OP_LOAD_WORD, 1'b0, 1'b1, 16'h0030, 32'h0, 32'h0000BEEF);
    u_mem.mem[8'h31] = 16'h0050;
    u_mem.mem[8'h50] = 16'h0000;
    u_mem.mem[8'h51] = 16'h0000;
    load(OP_LOAD_DOUBLE, 1'b0, 1'b1, 16'h0031, 32'h0, 32'h0);
    latency = 2'h1;
  endtask

  // octal digits one per nibble turn into a binary word
  task automatic t_load_addr();
    load(OP_LOAD_ADDR, 1'b1, 1'b0, 16'h0, 32'h00040400, 32'h00004100);
    load(OP_LOAD_ADDR, 1'b1, 1'b0, 16'h0, 32'h00177777, 32'h0000FFFF);
    load(OP_LOAD_ADDR, 1'b1, 1'b0, 16'h0, 32'h00000000, 32'h00000000);
  endtask

  task automatic t_manip();
    manip_result = 32'hA5A5F00F;
    simple(OP_MANIP);
    manip_result = 32'h00000000;
    simple(OP_MANIP);
  endtask

  // store and address load taken on two edges in a row: no push
  task automatic t_store_addr();
    @(negedge clk);
    op_valid = 1'b1;
    op_code = OP_STORE;
    @(negedge clk);
    op_code = OP_LOAD_ADDR;
    op_use_const = 1'b1;
    op_const = 32'h00002000;
    @(negedge clk);
    op_valid = 1'b0;
    exp_acc = 32'h00000400;
    exp_pend = 1'b1;
    exp_flag = 1'b0;
    compare_state();
  endtask

  // clock enable low: an offered instruction waits, nothing moves
  task automatic t_freeze();
    @(negedge clk);
    clk_en = 1'b0;
    manip_result = 32'h0F0F1234;
    op_valid = 1'b1;
    op_code = OP_MANIP;
    repeat (3) @(negedge clk);
    compare_state();
    check({31'h0, op_done}, 32'h00000000);
    clk_en = 1'b1;
    @(negedge clk);
    op_valid = 1'b0;
    exp_acc = 32'h0F0F1234;
    compare_state();
    check({31'h0, op_done}, 32'h00000001);
  endtask

  // run stops here if a handshake never completes
  initial begin
    #(40 * 8000);
    err_count++;
    $display("ERROR at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    test_done();
  end

  initial begin
    {op_valid, op_use_const, op_use_ptr} = 3'h0;
    clk_en = 1'b1;
    reset_n = 1'b0;
    op_code = OP_NOP;
    op_addr = 16'h0000;
    op_const = 32'h00000000;
    manip_result = 32'h00000000;
    latency = 2'h1;
    err_count = 0;
    samples_checked = 0;
    exp_acc = 32'h00000000;
    exp_pend = 1'b0;
    exp_flag = 1'b0;
    for (int i = 0; i < 8; i++) exp_stk[i] = 32'h00000000;
    repeat (20) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    t_reset_state();
    t_push_overflow();
    t_store_scan();
    t_mem_loads();
    t_load_addr();
    t_store_addr();
    t_manip();
    t_freeze();
    test_done();
  end
endmodule // test_accumulator_stack_load
`default_nettype wire

// ===== design/asl_fetch_if.sv
// operand fetch request and answer between sequencer and fetcher
`timescale 1ns/1ps
`default_nettype none
interface asl_fetch_if;
  import asl_pkg::*;
  logic                  start;       // one-cycle fetch request
  logic                  double_word; // two words form one operand
  logic                  use_ptr;     // operand address is indirect
  logic                  use_const;   // operand is the constant field
  logic [WORD_WIDTH-1:0] addr;        // word memory address
  logic [ACC_WIDTH-1:0]  const_val;   // immediate constant
  logic                  done;        // one-cycle answer pulse
  logic [ACC_WIDTH-1:0]  value;       // accumulator-wide operand

  modport requester (
    output start, double_word, use_ptr, use_const, addr, const_val,
    input  done, value
  );
  modport fetcher (
    input  start, double_word, use_ptr, use_const, addr, const_val,
    output done, value
  );
endinterface
`default_nettype wire

// ===== design/asl_operand.sv
// operand fetcher: constant, direct, pointer and double-word reads
`timescale 1ns/1ps
`default_nettype none
module asl_operand import asl_pkg::*; (
  input  wire logic                  clk,         // cpu clock
  input  wire logic                  reset_n,     // async reset, low
  input  wire logic                  clk_en,      // freezes state when low
  asl_fetch_if.fetcher               fif,         // fetch request/answer
  output logic                       mem_rd_req,  // read request, level
  output logic      [WORD_WIDTH-1:0] mem_rd_addr, // read address
  input  wire logic [WORD_WIDTH-1:0] mem_rd_data, // read data with ack
  input  wire logic                  mem_rd_ack   // read answer, pulse
);

  typedef enum logic [1:0] {F_IDLE, F_PTR, F_LO, F_HI} asl_fetch_state_type;

  asl_fetch_state_type   state_reg;
  logic [WORD_WIDTH-1:0] addr_reg;
  logic [WORD_WIDTH-1:0] lo_reg;
  logic                  double_reg;
  logic [ACC_WIDTH-1:0]  value_reg;
  logic                  done_reg;

  // sequencing and addresses
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg  <= F_IDLE;
      addr_reg   <= UPPER_ZERO;
      double_reg <= 1'b0;
    end else if (clk_en) begin
      case (state_reg)
        F_IDLE: if (fif.start && !fif.use_const) begin
          addr_reg   <= fif.addr;
          double_reg <= fif.double_word;
          state_reg  <= fif.use_ptr ? F_PTR : F_LO;
        end
        F_PTR: if (mem_rd_ack) begin
          // pointer content is a plain binary address, no octal decode
          addr_reg  <= mem_rd_data;
          state_reg <= F_LO;
        end
        F_LO: if (mem_rd_ack) begin
          if (double_reg) begin
            addr_reg  <= addr_reg + PAIR_STEP;
            state_reg <= F_HI;
          end else begin
            state_reg <= F_IDLE;
          end
        end
        F_HI: if (mem_rd_ack) begin
          state_reg <= F_IDLE;
        end
        default: state_reg <= F_IDLE;
      endcase
    end
  end

  // operand assembly and answer pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      value_reg <= ACC_RESET;
      lo_reg    <= UPPER_ZERO;
      done_reg  <= 1'b0;
    end else if (clk_en) begin
      done_reg <= 1'b0;
      if (state_reg == F_IDLE && fif.start && fif.use_const) begin
        value_reg <= fif.double_word ? fif.const_val
          : {UPPER_ZERO, fif.const_val[WORD_WIDTH-1:0]};
        done_reg  <= 1'b1;
      end else if (state_reg == F_LO && mem_rd_ack) begin
        lo_reg <= mem_rd_data;
        if (!double_reg) begin
          value_reg <= {UPPER_ZERO, mem_rd_data};
          done_reg  <= 1'b1;
        end
      end else if (state_reg == F_HI && mem_rd_ack) begin
        value_reg <= {mem_rd_data, lo_reg};
        done_reg  <= 1'b1;
      end
    end
  end

  assign mem_rd_req  = (state_reg != F_IDLE);
  assign mem_rd_addr = addr_reg;
  assign fif.done    = done_reg;
  assign fif.value   = value_reg;

  a_ptr_indirect: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && state_reg == F_PTR && mem_rd_ack
    |=> mem_rd_addr == $past(mem_rd_data))
    else $error("pointer value not used as read address");

  a_double_pair: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && state_reg == F_LO && mem_rd_ack && double_reg
    |=> mem_rd_req && mem_rd_addr == $past(mem_rd_addr) + PAIR_STEP)
    else $error("second word not read from next location");

endmodule // asl_operand
`default_nettype wire

// ===== design/asl_pkg.sv
// shared constants, types and helpers of the accumulator/stack datapath
package asl_pkg;

  // datapath widths
  localparam int ACC_WIDTH   = 32;
  localparam int WORD_WIDTH  = 16;
  localparam int STACK_DEPTH = 8;
  localparam int OCT_DIGITS  = 6;   // octal digits feeding a 16-bit address

  // values after reset
  localparam logic [ACC_WIDTH-1:0]  ACC_RESET   = 32'h00000000;
  localparam logic [ACC_WIDTH-1:0]  STACK_RESET = 32'h00000000;
  localparam logic [WORD_WIDTH-1:0] UPPER_ZERO  = 16'h0000;
  localparam logic                  FLAG_RESET  = 1'b0;
  localparam logic                  PEND_RESET  = 1'b0;

  // step between the two words of a double operand
  localparam logic [WORD_WIDTH-1:0] PAIR_STEP = 16'h0001;

  // instruction kinds issued by the sequencer
  typedef enum logic [2:0] {
    OP_NOP,
    OP_LOAD_WORD,
    OP_LOAD_DOUBLE,
    OP_LOAD_ADDR,
    OP_STORE,
    OP_POP,
    OP_MANIP,
    OP_SCAN_END
  } asl_op_type;

  // octal digits held one per nibble, packed to a binary word
  function automatic logic [WORD_WIDTH-1:0] asl_oct_to_bin(
    input logic [ACC_WIDTH-1:0] digits
  );
    logic [3*OCT_DIGITS-1:0] packed_bits;
    packed_bits = '0;
    for (int i = 0; i < OCT_DIGITS; i++) begin
      packed_bits[3*i +: 3] = digits[4*i +: 3];
    end
    return packed_bits[WORD_WIDTH-1:0];
  endfunction

endpackage

// ===== design/asl_stack.sv
// push-down stack of accumulator-wide levels
`timescale 1ns/1ps
`default_nettype none
module asl_stack import asl_pkg::*; #(
  parameter int DEPTH = STACK_DEPTH
) (
  input  wire logic                 clk,      // cpu clock
  input  wire logic                 reset_n,  // async reset, low
  input  wire logic                 clk_en,   // freezes state when low
  input  wire logic                 push,     // shift down, insert
  input  wire logic                 pop,      // shift up, fill zero
  input  wire logic [ACC_WIDTH-1:0] push_val, // value for top level
  output logic      [ACC_WIDTH-1:0] top_val   // top level
);

  logic [ACC_WIDTH-1:0] level_reg [DEPTH];

  if (DEPTH < 2) begin : g_bad_depth
    $error("asl_stack needs at least two levels");
  end

  // one register per level; push wins if both are asked
  for (genvar i = 0; i < DEPTH; i++) begin : g_level
    logic [ACC_WIDTH-1:0] from_above; // value a push moves in
    logic [ACC_WIDTH-1:0] from_below; // value a pop moves in

    // end levels get their own sources, so no select runs off the array
    if (i == 0) begin : g_top
      assign from_above = push_val;
    end else begin : g_dn
      assign from_above = level_reg[i-1];
    end
    if (i == DEPTH-1) begin : g_bottom
      assign from_below = STACK_RESET;
    end else begin : g_up
      assign from_below = level_reg[i+1];
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        level_reg[i] <= STACK_RESET;
      end else if (clk_en && push) begin
        // the last level is simply overwritten, so its value is lost
        level_reg[i] <= from_above;
      end else if (clk_en && pop) begin
        level_reg[i] <= from_below;
      end
    end
  end

  assign top_val = level_reg[0];

  a_stack_overflow: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && push |=> level_reg[DEPTH-1] == $past(level_reg[DEPTH-2]))
    else $error("bottom level not replaced by the one above");

  a_pop_fill_zero: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && pop && !push |=> level_reg[DEPTH-1] == STACK_RESET)
    else $error("bottom level not zero after pop");

endmodule // asl_stack
`default_nettype wire

// ===== design/asl_top.sv
// accumulator and push-down stack datapath driven by the sequencer
//
// Behaviour
// - one 32-bit accumulator for all data work
// - accumulator keeps BCD or binary bits unchanged
// - scan end clears the accumulator to zero
// - first load of a scan never pushes
// - later loads push old accumulator, then load
// - store cancels the push of the next load
// - push shifts levels down, accumulator to top
// - stack has eight 32-bit levels
// - push with full stack loses eighth level
// - pop moves top into accumulator, shifts up
// - data operation result replaces the accumulator
// - double operands pair two consecutive words
// - pointer operand reads address held in pointer
// - pointer contents are a binary address
// - word load zero-fills the upper half
// - zero flag set when a load gives zero
`timescale 1ns/1ps
`default_nettype none
module asl_top import asl_pkg::*; #(
  parameter int LEVELS = STACK_DEPTH
) (
  input  wire logic                  clk,            // cpu clock, 25 MHz
  input  wire logic                  reset_n,        // async reset, low
  input  wire logic                  clk_en,         // freezes state when low
  input  wire logic                  op_valid,       // instruction offered
  input  wire asl_op_type            op_code,        // instruction kind
  input  wire logic                  op_use_const,   // operand is constant
  input  wire logic                  op_use_ptr,     // operand via pointer
  input  wire logic [WORD_WIDTH-1:0] op_addr,        // operand word address
  input  wire logic [ACC_WIDTH-1:0]  op_const,       // constant / octal digits
  input  wire logic [ACC_WIDTH-1:0]  manip_result,   // result of data op
  output logic                       op_ready,       // ready to take an instruction
  output logic                       op_done,        // finished, pulse
  output logic      [ACC_WIDTH-1:0]  acc_out,        // accumulator
  output logic      [ACC_WIDTH-1:0]  stack_top_out,  // top stack level
  output logic                       zero_load_flag, // last load was zero
  output logic                       mem_rd_req,     // word read request
  output logic      [WORD_WIDTH-1:0] mem_rd_addr,    // word read address
  input  wire logic [WORD_WIDTH-1:0] mem_rd_data,    // word read data
  input  wire logic                  mem_rd_ack      // word read answer
);

  typedef enum logic {S_IDLE, S_FETCH} asl_seq_state_type;

  if (LEVELS != STACK_DEPTH) begin : g_bad_levels
    $error("asl_top stack depth is fixed at eight levels");
  end

  asl_fetch_if fif ();

  asl_seq_state_type    state_reg;
  logic [ACC_WIDTH-1:0] acc_reg;
  logic                 push_pend_reg;
  logic                 zero_flag_reg;
  logic                 done_reg;
  logic [ACC_WIDTH-1:0] stack_top;

  logic                 take;
  logic                 mem_load;
  logic                 fetch_end;
  logic                 commit_load;
  logic [ACC_WIDTH-1:0] load_value;
  logic                 push;
  logic                 pop;
  logic                 word_fetch_reg;

  // instruction acceptance; one instruction in flight at a time
  assign op_ready  = (state_reg == S_IDLE);
  assign take      = clk_en && op_valid && op_ready;
  assign mem_load  = (op_code == OP_LOAD_WORD) || (op_code == OP_LOAD_DOUBLE);
  assign fetch_end = clk_en && (state_reg == S_FETCH) && fif.done;

  // loads commit either on fetch answer or at once for address convert
  assign commit_load = fetch_end || (take && op_code == OP_LOAD_ADDR);
  assign load_value  = (state_reg == S_FETCH) ? fif.value
    : {UPPER_ZERO, asl_oct_to_bin(op_const)};

  // push only when a load follows a load with no store between
  assign push = commit_load && push_pend_reg;
  assign pop  = take && (op_code == OP_POP);

  // fetch request toward the operand fetcher
  assign fif.start       = take && mem_load;
  assign fif.double_word = (op_code == OP_LOAD_DOUBLE);
  assign fif.use_ptr     = op_use_ptr;
  assign fif.use_const   = op_use_const;
  assign fif.addr        = op_addr;
  assign fif.const_val   = op_const;

  asl_operand u_operand (
    .clk         (clk),
    .reset_n     (reset_n),
    .clk_en      (clk_en),
    .fif         (fif),
    .mem_rd_req  (mem_rd_req),
    .mem_rd_addr (mem_rd_addr),
    .mem_rd_data (mem_rd_data),
    .mem_rd_ack  (mem_rd_ack)
  );

  asl_stack #(
    .DEPTH (LEVELS)
  ) u_stack (
    .clk      (clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .push     (push),
    .pop      (pop),
    .push_val (acc_reg),
    .top_val  (stack_top)
  );

  // sequencer state: wait for the fetcher only on memory loads
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
    end else if (clk_en) begin
      case (state_reg)
        S_IDLE:  if (take && mem_load) state_reg <= S_FETCH;
        S_FETCH: if (fif.done) state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // accumulator; bits are stored as given, never reformatted
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_reg <= ACC_RESET;
    end else if (clk_en) begin
      if (commit_load) begin
        acc_reg <= load_value;
      end else if (take) begin
        case (op_code)
          OP_SCAN_END: acc_reg <= ACC_RESET;
          OP_POP:      acc_reg <= stack_top;
          OP_MANIP:    acc_reg <= manip_result;
          default:     acc_reg <= acc_reg;
        endcase
      end
    end
  end

  // pending push: armed by a load, cancelled by store or scan end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      push_pend_reg <= PEND_RESET;
    end else if (clk_en) begin
      if (commit_load) begin
        push_pend_reg <= 1'b1;
      end else if (take && op_code == OP_STORE) begin
        push_pend_reg <= 1'b0;
      end else if (take && op_code == OP_SCAN_END) begin
        push_pend_reg <= 1'b0;
      end
    end
  end

  // zero flag follows each load; other instructions leave it alone
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zero_flag_reg <= FLAG_RESET;
    end else if (clk_en && commit_load) begin
      zero_flag_reg <= (load_value == ACC_RESET);
    end
  end

  // remembers that the fetch in flight serves a 16-bit word load, so the
  // zero-fill check does not depend on op_code still standing at the end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      word_fetch_reg <= 1'b0;
    end else if (take && mem_load) begin
      word_fetch_reg <= (op_code == OP_LOAD_WORD);
    end
  end

  // completion pulse in the same cycle the accumulator shows its new value
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_reg <= 1'b0;
    end else if (clk_en) begin
      done_reg <= (take && !mem_load) || fetch_end;
    end
  end

  assign op_done        = done_reg;
  assign acc_out        = acc_reg;
  assign stack_top_out  = stack_top;
  assign zero_load_flag = zero_flag_reg;

  // checks of the accumulator and stack behaviour
  a_scan_clear: assert property (@(posedge clk) disable iff (!reset_n)
    take && op_code == OP_SCAN_END |=> acc_reg == ACC_RESET
      && !push_pend_reg)
    else $error("scan end did not clear accumulator");

  a_first_load: assert property (@(posedge clk) disable iff (!reset_n)
    commit_load && !push_pend_reg |=> stack_top == $past(stack_top))
    else $error("first load disturbed the stack");

  a_load_push: assert property (@(posedge clk) disable iff (!reset_n)
    commit_load && push_pend_reg
    |=> stack_top == $past(acc_reg) && acc_reg == $past(load_value))
    else $error("second load did not push old accumulator");

  a_store_cancel: assert property (@(posedge clk) disable iff (!reset_n)
    take && op_code == OP_STORE ##1 take && op_code == OP_LOAD_ADDR
    |=> stack_top == $past(stack_top, 2))
    else $error("load after store pushed");

  a_pop_rotate: assert property (@(posedge clk) disable iff (!reset_n)
    pop |=> acc_reg == $past(stack_top))
    else $error("pop did not move top into accumulator");

  a_manip_result: assert property (@(posedge clk) disable iff (!reset_n)
    take && op_code == OP_MANIP |=> acc_reg == $past(manip_result))
    else $error("result not placed in accumulator");

  a_word_zero_fill: assert property (@(posedge clk) disable iff (!reset_n)
    fetch_end && word_fetch_reg
    |=> acc_reg[ACC_WIDTH-1:WORD_WIDTH] == UPPER_ZERO)
    else $error("word load left upper half set");

  a_zero_flag: assert property (@(posedge clk) disable iff (!reset_n)
    commit_load |=> zero_load_flag == (acc_reg == ACC_RESET))
    else $error("zero flag disagrees with loaded value");

  a_addr_convert: assert property (@(posedge clk) disable iff (!reset_n)
    take && op_code == OP_LOAD_ADDR
    |=> acc_reg == {UPPER_ZERO, asl_oct_to_bin($past(op_const))})
    else $error("address conversion wrong");

  a_done_timing: assert property (@(posedge clk) disable iff (!reset_n)
    take && !mem_load |=> op_done && op_ready)
    else $error("single-cycle instruction not finished in one cycle");

  // main scenarios
  c_load_push: cover property (@(posedge clk) disable iff (!reset_n)
    push);

  c_pop_after_push: cover property (@(posedge clk) disable iff (!reset_n)
    push ##[1:20] pop);

  c_ptr_double: cover property (@(posedge clk) disable iff (!reset_n)
    take && op_code == OP_LOAD_DOUBLE && op_use_ptr ##[3:40] fetch_end);

  c_store_then_load: cover property (@(posedge clk) disable iff (!reset_n)
    take && op_code == OP_STORE ##[1:10] commit_load);

endmodule // asl_top
`default_nettype wire
